// file: sim/dsiop_rx_model.sv
// Behavioural receive port of the external DSP that captures both serial lines.
`timescale 1ns/1ps
module dsiop_rx_model (
    input  wire logic        sclk,
    input  wire logic        clr,
    input  wire logic        data_a,
    input  wire logic        oe_a,
    input  wire logic        data_b,
    input  wire logic        oe_b,
    output logic      [47:0] word_a,
    output logic      [47:0] word_b,
    output logic      [5:0]  nbits
);
    // Sampling on the falling edge keeps clear of the bit change at the rise.
    always @(negedge sclk or posedge clr) begin
        if (clr) begin
            word_a <= '0;
            word_b <= '0;
            nbits  <= '0;
        end else if (oe_a) begin
            word_a <= {word_a[46:0], data_a};
            word_b <= {word_b[46:0], oe_b ? data_b : ~word_b[0]};
            nbits  <= nbits + 6'h01;
        end
    end
endmodule : dsiop_rx_model

// file: sim/dsiop_top_tb.sv
// Self-checking testbench of the dual serial I/Q output port.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module dsiop_top_tb
    import dsiop_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, rx_clr;
    logic sclk_out, frame_sync_out, data_ready_pin;
    logic serial_data_out_a, serial_data_out_a_oe, serial_data_out_b, serial_data_out_b_oe;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] ia = 24'h9c3a5f, qa = 24'h1b6e02, ib = 24'hc4d817, qb = 24'h7f0193;
    logic [47:0] word_a, word_b;
    logic [5:0]  nbits;
    logic        er;
    int          err_count = 0, checks_done = 0, cyc = 0, fsn;

    dsiop_top dsiop_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_i_a(ia), .sample_q_a(qa), .sample_i_b(ib), .sample_q_b(qb),
        .sclk_out(sclk_out), .frame_sync_out(frame_sync_out),
        .data_ready_pin(data_ready_pin), .serial_data_out_a(serial_data_out_a),
        .serial_data_out_a_oe(serial_data_out_a_oe), .serial_data_out_b(serial_data_out_b),
        .serial_data_out_b_oe(serial_data_out_b_oe));

    dsiop_rx_model dsiop_rx_model_i (.sclk(sclk_out), .clr(rx_clr),
        .data_a(serial_data_out_a), .oe_a(serial_data_out_a_oe),
        .data_b(serial_data_out_b), .oe_b(serial_data_out_b_oe),
        .word_a(word_a), .word_b(word_b), .nbits(nbits));

    // ****************************************************************
    // Bus and stream helpers
    // ****************************************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // A hang ends the run through the same report as a normal finish.
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic post_sample();
        @(posedge pclk);
        rx_clr       <= 1'b1;
        sample_valid <= 1'b1;
        @(posedge pclk);
        rx_clr       <= 1'b0;
        sample_valid <= 1'b0;
        @(negedge pclk);
        `CHK(data_ready_pin, 1'b1)
        fsn = 0;
    endtask : post_sample

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic reset_and_regs();
        @(negedge pclk);
        `CHK({frame_sync_out, serial_data_out_a_oe, serial_data_out_b_oe}, 3'h0)
        apb(1'b0, CTRL_ADDR, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b1, CTRL_ADDR, 32'hffff_fff7);
        apb(1'b0, CTRL_ADDR, 32'h0);
        `CHK(rd, 32'h0000_00f7)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        apb(1'b1, CTRL_ADDR, 32'h0000_0081);
        post_sample();
        repeat (60) @(negedge pclk) fsn += int'(frame_sync_out);
        `CHK(fsn, 0)
        // A second reset drops the result left pending while master was off.
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        `CHK({data_ready_pin, frame_sync_out, serial_data_out_a_oe}, 3'h0)
        apb(1'b0, CTRL_ADDR, 32'h0);
        `CHK(rd, 32'h0)
    endtask : reset_and_regs

    task automatic frame_check(input logic [2:0] dv, input logic wl, input logic [1:0] md);
        int          w, busy, fx;
        logic        seen;
        w    = wl ? 24 : 16;
        busy = 0;
        seen = 1'b0;
        fx   = md == 2'b11 ? (2 * w + 1) * (dv + 1) : (md == 2'b10 ? 2 : 1) * (dv + 1);
        apb(1'b1, CTRL_ADDR, {24'h0, 1'b1, md, wl, 1'b1, dv});
        post_sample();
        for (int n = 0; n < 1000; n++) begin
            @(negedge pclk);
            if (serial_data_out_a_oe && !seen) begin
                seen = 1'b1;
                `CHK(fsn, dv + 1)
            end
            fsn += int'(frame_sync_out);
            busy += int'(frame_sync_out | serial_data_out_a_oe);
            if (seen && !serial_data_out_a_oe) break;
        end
        `CHK(busy, (2 * w + 1) * (dv + 1))
        `CHK(fsn, fx)
        `CHK(nbits, 6'(2 * w))
        `CHK(word_a, wl ? {ia, qa} : {16'h0, ia[23:8], qa[23:8]})
        `CHK(word_b, wl ? {ib, qb} : {16'h0, ib[23:8], qb[23:8]})
        `CHK(serial_data_out_b_oe, 1'b0)
    endtask : frame_check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        {presetn, psel, penable, pwrite, sample_valid, rx_clr} = '0;
        paddr  = '0;
        pwdata = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        reset_and_regs();
        frame_check(3'd1, 1'b1, 2'b00);
        frame_check(3'd2, 1'b0, 2'b01);
        frame_check(3'd7, 1'b1, 2'b10);
        frame_check(3'd3, 1'b0, 2'b11);
        frame_check(3'd1, 1'b0, 2'b10);
        apb(1'b0, STAT_ADDR, 32'h0);
        `CHK(rd & 32'h0000_ff07, 32'h0000_0500)
        tally_and_finish();
    end
endmodule : dsiop_top_tb

// file: verilog/dsiop_clkdiv.sv
// Counter divider that makes the shift clock and its rising-edge enable.
`timescale 1ns/1ps
module dsiop_clkdiv
    import dsiop_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [DIV_W-1:0] div,
    output logic                  sclk,
    output logic                  rise_en
);

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic [DIV_W:0]   high_len;

    // A divider change mid-period is absorbed by wrapping at or above the new limit.
    assign rise_en  = (cnt >= div);
    assign next_cnt = rise_en ? '0 : DIV_W'(cnt + 1'b1);
    assign high_len = (DIV_W+1)'(({1'b0, div} + 2'd2) >> 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // At ratio 1 the clock cannot toggle from a flop, so it stays high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk <= 1'b0;
        end else begin
            sclk <= ({1'b0, next_cnt} < high_len);
        end
    end

endmodule : dsiop_clkdiv

// file: verilog/dsiop_pkg.sv
// Shared constants, register map and enumerations of the dual serial I/Q output port.
package dsiop_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int          CTRL_IDX    = 'h21;
    localparam int          STAT_IDX    = 'h22;
    localparam logic [7:0]  CTRL_ADDR   = 8'(CTRL_IDX * 4);
    localparam logic [7:0]  STAT_ADDR   = 8'(STAT_IDX * 4);
    localparam logic [15:0] CTRL_RESET  = 16'h0000;
    localparam logic [7:0]  CTRL_MASK   = 8'hff;

    // ****************************************************************
    // Control fields
    // ****************************************************************
    localparam int DIV_LSB    = 0;
    localparam int DIV_W      = 3;
    localparam int MASTER_BIT = 3;
    localparam int WL_BIT     = 4;
    localparam int FS_LSB     = 5;
    localparam int DUAL_BIT   = 7;

    // ****************************************************************
    // Status fields
    // ****************************************************************
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_OVR_BIT  = 2;
    localparam int STAT_CNT_LSB  = 8;

    // ****************************************************************
    // Word geometry
    // ****************************************************************
    localparam int         SAMPLE_W   = 24;
    localparam int         SHORT_W    = 16;
    localparam int         FRAME_W    = 2 * SAMPLE_W;
    localparam logic [5:0] LAST_SHORT = 6'(2 * SHORT_W - 1);
    localparam logic [5:0] LAST_LONG  = 6'(2 * SAMPLE_W - 1);
    localparam logic [5:0] LASTI_SHORT = 6'(SHORT_W - 1);
    localparam logic [5:0] LASTI_LONG  = 6'(SAMPLE_W - 1);

    typedef enum logic [1:0] {
        FS_PULSE     = 2'b00,
        FS_PULSE_ALT = 2'b01,
        FS_SPLIT     = 2'b10,
        FS_LEVEL     = 2'b11
    } dsiop_fs_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SYNC  = 2'b01,
        ST_SHIFT = 2'b10
    } dsiop_state_t;

endpackage : dsiop_pkg

// file: verilog/dsiop_shifter.sv
// One serial output port: loads an I/Q pair and shifts it out MSB first.
`timescale 1ns/1ps
module dsiop_shifter
    import dsiop_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    dsiop_tick_if.port               tick,
    input  wire logic [SAMPLE_W-1:0] i_word,
    input  wire logic [SAMPLE_W-1:0] q_word,
    output logic                     data_out,
    output logic                     data_oe
);

    logic [FRAME_W-1:0] sr;
    logic [FRAME_W-1:0] loaded;

    // Short words keep the upper bits of each sample, so I and Q stay packed.
    assign loaded = tick.word24 ? {i_word, q_word}
                  : {i_word[SAMPLE_W-1 -: SHORT_W], q_word[SAMPLE_W-1 -: SHORT_W],
                     {(FRAME_W-2*SHORT_W){1'b0}}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr       <= '0;
            data_out <= 1'b0;
        end else if (tick.load) begin
            data_out <= loaded[FRAME_W-1];
            sr       <= {loaded[FRAME_W-2:0], 1'b0};
        end else if (tick.shift) begin
            data_out <= sr[FRAME_W-1];
            sr       <= {sr[FRAME_W-2:0], 1'b0};
        end else if (tick.stop) begin
            data_out <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_oe <= 1'b0;
        end else if (tick.load) begin
            data_oe <= 1'b1;
        end else if (tick.stop) begin
            data_oe <= 1'b0;
        end
    end

    load_msb_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick.load |=> data_oe && data_out == $past(i_word[SAMPLE_W-1]))
        else $error("first bit is not the I sign bit");

endmodule : dsiop_shifter

// file: verilog/dsiop_tick_if.sv
// Timing strobes shared by the frame controller and both shift ports.
`timescale 1ns/1ps
interface dsiop_tick_if;
    logic load;
    logic shift;
    logic stop;
    logic word24;

    modport ctrl (output load, output shift, output stop, output word24);
    modport port (input load, input shift, input stop, input word24);
endinterface : dsiop_tick_if

// file: verilog/dsiop_top.sv
// Dual serial I/Q output port with APB control and shared frame timing.
`timescale 1ns/1ps
module dsiop_top
    import dsiop_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic [7:0]          paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] sample_i_a,
    input  wire logic [SAMPLE_W-1:0] sample_q_a,
    input  wire logic [SAMPLE_W-1:0] sample_i_b,
    input  wire logic [SAMPLE_W-1:0] sample_q_b,
    output logic                     sclk_out,
    output logic                     frame_sync_out,
    output logic                     data_ready_pin,
    output logic                     serial_data_out_a,
    output logic                     serial_data_out_a_oe,
    output logic                     serial_data_out_b,
    output logic                     serial_data_out_b_oe
);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [7:0]       ctrl;
    logic             overrun;
    logic [7:0]       frame_cnt;
    logic             pending;
    dsiop_state_t     state;
    logic             setup;
    logic             wr_en;
    logic             hit_ctrl;
    logic             hit_stat;
    logic [31:0]      rd_mux;

    assign setup    = psel && !penable;
    assign wr_en    = psel && penable && pready && pwrite;
    assign hit_ctrl = (paddr == CTRL_ADDR);
    assign hit_stat = (paddr == STAT_ADDR);

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux[7:0] = ctrl;
        end else if (hit_stat) begin
            rd_mux[STAT_PEND_BIT]            = pending;
            rd_mux[STAT_BUSY_BIT]            = (state != ST_IDLE);
            rd_mux[STAT_OVR_BIT]             = overrun;
            rd_mux[STAT_CNT_LSB +: 8]        = frame_cnt;
        end
    end

    // The answer is prepared in the setup cycle so the access phase lasts one cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit_ctrl && !hit_stat;
            prdata  <= setup ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET[7:0];
        end else if (wr_en && hit_ctrl) begin
            ctrl <= pwdata[7:0] & CTRL_MASK;
        end
    end

    // ****************************************************************
    // Shift clock
    // ****************************************************************
    logic rise_en;

    // The divider flop drives the pin directly so data changes with the rising edge.
    dsiop_clkdiv u_clkdiv (
        .pclk    (pclk),
        .presetn (presetn),
        .div     (ctrl[DIV_LSB +: DIV_W]),
        .sclk    (sclk_out),
        .rise_en (rise_en)
    );

    // ****************************************************************
    // Sample buffer
    // ****************************************************************
    logic [SAMPLE_W-1:0] hold_i_a;
    logic [SAMPLE_W-1:0] hold_q_a;
    logic [SAMPLE_W-1:0] hold_i_b;
    logic [SAMPLE_W-1:0] hold_q_b;
    dsiop_tick_if        tick ();

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_i_a <= '0;
            hold_q_a <= '0;
            hold_i_b <= '0;
            hold_q_b <= '0;
        end else if (sample_valid && !tick.load) begin
            hold_i_a <= sample_i_a;
            hold_q_a <= sample_q_a;
            hold_i_b <= sample_i_b;
            hold_q_b <= sample_q_b;
        end
    end

    // A sample arriving on the load edge is not held; pending stays set and the next frame resends the old pair.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 1'b0;
        end else if (sample_valid) begin
            pending <= 1'b1;
        end else if (tick.load) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun <= 1'b0;
        end else if (sample_valid && pending) begin
            overrun <= 1'b1;
        end else if (wr_en && hit_stat && pwdata[STAT_OVR_BIT]) begin
            overrun <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_ready_pin <= 1'b0;
        end else begin
            data_ready_pin <= sample_valid || (pending && !tick.load);
        end
    end

    // ****************************************************************
    // Frame controller
    // ****************************************************************
    logic           f_word24;
    dsiop_fs_mode_t f_mode;
    logic [5:0]     bitcnt;
    logic           last_bit;
    logic [5:0]     next_bitcnt;
    logic           start;

    assign last_bit    = (bitcnt == (f_word24 ? LAST_LONG : LAST_SHORT));
    assign next_bitcnt = 6'(bitcnt + 1'b1);
    assign start       = rise_en && state == ST_IDLE && pending && ctrl[MASTER_BIT];
    assign tick.load   = rise_en && state == ST_SYNC;
    assign tick.shift  = rise_en && state == ST_SHIFT && !last_bit;
    assign tick.stop   = rise_en && state == ST_SHIFT && last_bit;
    assign tick.word24 = f_word24;

    // Word length and sync mode are frozen per frame so a write cannot tear one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            f_word24 <= 1'b0;
            f_mode   <= FS_PULSE;
        end else if (start) begin
            f_word24 <= ctrl[WL_BIT];
            f_mode   <= dsiop_fs_mode_t'(ctrl[FS_LSB +: 2]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else if (rise_en) begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_SYNC;
                    end
                end
                ST_SYNC: begin
                    state <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (last_bit) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bitcnt <= '0;
        end else if (tick.load) begin
            bitcnt <= '0;
        end else if (tick.shift) begin
            bitcnt <= next_bitcnt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_cnt <= '0;
        end else if (tick.stop) begin
            frame_cnt <= 8'(frame_cnt + 1'b1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_sync_out <= 1'b0;
        end else if (start) begin
            frame_sync_out <= 1'b1;
        end else if (tick.load) begin
            frame_sync_out <= (f_mode == FS_LEVEL);
        end else if (tick.shift) begin
            frame_sync_out <= (f_mode == FS_LEVEL) || (f_mode == FS_SPLIT &&
                              next_bitcnt == (f_word24 ? LASTI_LONG : LASTI_SHORT));
        end else if (tick.stop) begin
            frame_sync_out <= 1'b0;
        end
    end

    // ****************************************************************
    // Output ports
    // ****************************************************************
    dsiop_shifter u_port_a (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (tick.port),
        .i_word   (hold_i_a),
        .q_word   (hold_q_a),
        .data_out (serial_data_out_a),
        .data_oe  (serial_data_out_a_oe)
    );

    dsiop_shifter u_port_b (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (tick.port),
        .i_word   (hold_i_b),
        .q_word   (hold_q_b),
        .data_out (serial_data_out_b),
        .data_oe  (serial_data_out_b_oe)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [3:0] gap;
    logic       div_chg;
    logic [5:0] oe_bits;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap     <= '0;
            div_chg <= 1'b1;
            oe_bits <= '0;
        end else begin
            gap     <= rise_en ? 4'h0 : 4'(gap + 1'b1);
            div_chg <= (wr_en && hit_ctrl) || (div_chg && !rise_en);
            oe_bits <= !serial_data_out_a_oe ? 6'h00 : rise_en ? 6'(oe_bits + 1'b1) : oe_bits;
        end
    end

    ports_same_a: assert property (@(posedge pclk) disable iff (!presetn)
        serial_data_out_a_oe == serial_data_out_b_oe)
        else $error("ports disagree on their transmit slot");

    div_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        rise_en && !div_chg |-> gap == {1'b0, ctrl[DIV_LSB +: DIV_W]})
        else $error("shift clock period differs from divider plus one");

    sync_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        start |=> frame_sync_out && state == ST_SYNC)
        else $error("frame sync did not rise for buffered data");

    first_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_SYNC && rise_en |=> serial_data_out_a_oe && bitcnt == 6'h00)
        else $error("first bit not driven after frame sync");

    word_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(serial_data_out_a_oe) |->
            oe_bits == (f_word24 ? 6'(LAST_LONG + 1'b1) : 6'(LAST_SHORT + 1'b1)))
        else $error("frame length does not match word length");

    level_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        f_mode == FS_LEVEL && serial_data_out_a_oe |-> frame_sync_out)
        else $error("level sync dropped during valid bits");

    pulse_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        frame_sync_out && (f_mode == FS_PULSE || f_mode == FS_PULSE_ALT) |-> !serial_data_out_a_oe)
        else $error("single pulse sync overlaps data");

    idle_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_IDLE |-> !serial_data_out_a_oe && !serial_data_out_b_oe)
        else $error("data driven outside the transmit slot");

    master_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_IDLE && !ctrl[MASTER_BIT] |=> !frame_sync_out)
        else $error("frame sync issued without master enable");

    ready_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        sample_valid |=> data_ready_pin && pending)
        else $error("new result not buffered");

endmodule : dsiop_top
